// >>> iob_channel_ctl.sv
// buffered channel controller with counted jump
// Contract
// - counted jump with nonzero index jumps to Y and decrements index
// - counted jump with zero index falls through, index unchanged
// - taken jump uses only the low 15 bits of Y
// - input buffer arms channel to store words from Y, peripheral paced
// - current address incremented before every buffered word moves
// - input running address kept in low half of word 00100 plus j
// - output buffer reads core, address kept in word 00120 plus j
// - buffer active until re-init, terminate, or control halves equal
// - interpretation 3 writes the whole operand word into control word
// - interpretation 1 writes operand low 15 bits, upper half kept
// - interpretation 0 writes Y itself into low half, upper kept
// - setup then next instruction at once; interpretation 2 forbidden
// - monitored input buffer interrupts when halves become equal
// - monitored output buffer interrupts on completion
// - terminate deactivates buffer, no interrupt, operand fields ignored
// - input word: request, device samples and acknowledges, then drop
// - output word: request, device drives data and ack, then removes
`timescale 1ns/100ps
`include "iob_defines.svh"
module iob_channel_ctl
   import iob_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic instr_valid_in,
   input wire logic [5:0] instr_op_in,
   input wire logic [3:0] instr_j_in,
   input wire logic [1:0] instr_k_in,
   input wire logic [14:0] instr_y_in,
   input wire logic [29:0] instr_operand_in,
   input wire logic [14:0] index_val_in,
   output logic instr_ready_out,
   output logic instr_done_out,
   output logic jmp_valid_out,
   output logic jmp_taken_out,
   output logic [14:0] jmp_addr_out,
   output logic bidx_we_out,
   output logic [14:0] bidx_wdata_out,
   output logic core_req_out,
   output logic core_we_out,
   output logic [14:0] core_addr_out,
   output logic [29:0] core_wdata_out,
   input wire logic [29:0] core_rdata_in,
   input wire logic [11:0] in_req_in,
   input wire logic [11:0][29:0] in_data_in,
   output logic [11:0] in_ack_out,
   input wire logic [11:0] out_req_in,
   output logic [11:0] out_ack_out,
   output logic [11:0][29:0] out_data_out,
   output logic [11:0] in_active_out,
   output logic [11:0] out_active_out,
   output logic mon_irq_out,
   output logic mon_dir_out,
   output logic [3:0] mon_ch_out
);
   iob_regs_t st;
   iob_regs_t nx;
   logic cw_we;
   logic [4:0] cw_waddr;
   logic [4:0] cw_raddr;
   logic [29:0] cw_wdata;
   logic [29:0] cw_rdata;
   logic [11:0] pend_i;
   logic [11:0] pend_o;
   logic [14:0] nlow;
   logic is_init;
   logic accept;

   function automatic logic [4:0] cw_idx(input logic d, input logic [3:0] c);
      logic [14:0] loc;
      logic [14:0] off;
      loc = (d ? `IOB_LOC_OUT : `IOB_LOC_IN) + {11'h000, c};
      off = loc - `IOB_LOC_BASE;
      return off[4:0];
   endfunction

   iob_cw_mem u_cw_mem
   (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .we_in(cw_we),
      .waddr_in(cw_waddr),
      .wdata_in(cw_wdata),
      .raddr_in(cw_raddr),
      .rdata_out(cw_rdata)
   );

   // ************************************************************
   // next state
   // ************************************************************
   assign accept = instr_valid_in && (st.state == ST_IDLE);
   assign is_init = (instr_op_in == `IOB_OP_IBUF) ||
                    (instr_op_in == `IOB_OP_OBUF) ||
                    (instr_op_in == `IOB_OP_IBUF_MON) ||
                    (instr_op_in == `IOB_OP_OBUF_MON);
   assign pend_i = st.act_i & st.rq_i_s2 & ~st.ack_i;
   assign pend_o = st.act_o & st.rq_o_s2 & ~st.ack_o;
   assign nlow = cw_rdata[14:0] + 15'h0001;

   always_comb
   begin
      nx = st;
      cw_we = 1'b0;
      cw_waddr = 5'h00;
      cw_wdata = 30'h0;
      cw_raddr = 5'h00;
      nx.jmp_valid = 1'b0;
      nx.b_we = 1'b0;
      nx.done = 1'b0;
      nx.irq = 1'b0;
      nx.core_req = 1'b0;
      nx.core_we = 1'b0;
      // pins pass two stages; data passes the same two stages in step with its request
      nx.rq_i_s1 = in_req_in;
      nx.rq_i_s2 = st.rq_i_s1;
      nx.rq_o_s1 = out_req_in;
      nx.rq_o_s2 = st.rq_o_s1;
      nx.id_s1 = in_data_in;
      nx.id_s2 = st.id_s1;
      for (int i = 0; i < `IOB_NCH; i++)
      begin
         if (st.ack_i[i] && !st.rq_i_s2[i])
            nx.ack_i[i] = 1'b0;
         if (st.ack_o[i] && !st.rq_o_s2[i])
         begin
            nx.ack_o[i] = 1'b0;
            nx.odata[i] = 30'h0;
         end
      end
      case (st.state)
         ST_IDLE:
         begin
            if (accept)
            begin
               nx.op = instr_op_in;
               nx.ch = instr_j_in;
               nx.k = instr_k_in;
               nx.y = instr_y_in;
               nx.opnd = instr_operand_in;
               nx.dir = (instr_op_in == `IOB_OP_OBUF) ||
                        (instr_op_in == `IOB_OP_OBUF_MON);
               if (instr_op_in == `IOB_OP_BJUMP)
               begin
                  nx.jmp_valid = 1'b1;
                  nx.jmp_taken = (index_val_in != 15'h0000);
                  nx.jmp_addr = instr_y_in;
                  nx.b_we = (index_val_in != 15'h0000);
                  nx.b_wdata = index_val_in - 15'h0001;
               end
               else if (instr_j_in >= `IOB_NCH_LIM)
                  nx.done = 1'b1;
               else if (instr_op_in == `IOB_OP_TERM_IN)
               begin
                  nx.act_i[instr_j_in] = 1'b0;
                  nx.mon_i[instr_j_in] = 1'b0;
                  nx.done = 1'b1;
               end
               else if (instr_op_in == `IOB_OP_TERM_OUT)
               begin
                  nx.act_o[instr_j_in] = 1'b0;
                  nx.mon_o[instr_j_in] = 1'b0;
                  nx.done = 1'b1;
               end
               else if (is_init)
               begin
                  cw_raddr = cw_idx(nx.dir, instr_j_in);
                  nx.state = ST_INIT_WR;
               end
               else
                  nx.done = 1'b1;
            end
            else if ((pend_i | pend_o) != 12'h000)
            begin
               // inputs win over outputs, lower channel numbers first
               for (int i = `IOB_NCH - 1; i >= 0; i--)
               begin
                  if (pend_o[i])
                  begin
                     nx.ch = 4'(i);
                     nx.dir = 1'b1;
                  end
               end
               for (int i = `IOB_NCH - 1; i >= 0; i--)
               begin
                  if (pend_i[i])
                  begin
                     nx.ch = 4'(i);
                     nx.dir = 1'b0;
                  end
               end
               cw_raddr = cw_idx(nx.dir, nx.ch);
               nx.state = ST_SVC_WR;
            end
         end
         ST_INIT_WR:
         begin
            cw_we = 1'b1;
            cw_waddr = cw_idx(st.dir, st.ch);
            case (st.k)
               `IOB_K_FULL: cw_wdata = st.opnd;
               `IOB_K_LOW: cw_wdata = {cw_rdata[29:15], st.opnd[14:0]};
               `IOB_K_ADDR: cw_wdata = {cw_rdata[29:15], st.y};
               default: cw_wdata = cw_rdata;
            endcase
            // a new initiation supersedes any buffer of the same direction on the channel
            if (st.dir)
            begin
               nx.act_o[st.ch] = 1'b1;
               nx.mon_o[st.ch] = (st.op == `IOB_OP_OBUF_MON);
            end
            else
            begin
               nx.act_i[st.ch] = 1'b1;
               nx.mon_i[st.ch] = (st.op == `IOB_OP_IBUF_MON);
            end
            nx.done = 1'b1;
            nx.state = ST_IDLE;
         end
         ST_SVC_WR:
         begin
            cw_we = 1'b1;
            cw_waddr = cw_idx(st.dir, st.ch);
            cw_wdata = {cw_rdata[29:15], nlow};
            nx.core_req = 1'b1;
            nx.core_addr = nlow;
            if (st.dir)
               nx.state = ST_SVC_WAIT;
            else
            begin
               nx.core_we = 1'b1;
               nx.core_wdata = st.id_s2[st.ch];
               nx.ack_i[st.ch] = 1'b1;
               nx.state = ST_IDLE;
            end
            if (nlow == cw_rdata[29:15])
            begin
               nx.irq_ch = st.ch;
               nx.irq_dir = st.dir;
               if (st.dir)
               begin
                  nx.act_o[st.ch] = 1'b0;
                  nx.irq = st.mon_o[st.ch];
                  nx.mon_o[st.ch] = 1'b0;
               end
               else
               begin
                  nx.act_i[st.ch] = 1'b0;
                  nx.irq = st.mon_i[st.ch];
                  nx.mon_i[st.ch] = 1'b0;
               end
            end
         end
         ST_SVC_WAIT:
            nx.state = ST_SVC_OUT;
         ST_SVC_OUT:
         begin
            nx.odata[st.ch] = core_rdata_in;
            nx.ack_o[st.ch] = 1'b1;
            nx.state = ST_IDLE;
         end
         default:
            nx.state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         st <= '0;
      else
         st <= nx;
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign instr_ready_out = (st.state == ST_IDLE);
   assign instr_done_out = st.done;
   assign jmp_valid_out = st.jmp_valid;
   assign jmp_taken_out = st.jmp_taken;
   assign jmp_addr_out = st.jmp_addr;
   assign bidx_we_out = st.b_we;
   assign bidx_wdata_out = st.b_wdata;
   assign core_req_out = st.core_req;
   assign core_we_out = st.core_we;
   assign core_addr_out = st.core_addr;
   assign core_wdata_out = st.core_wdata;
   assign in_ack_out = st.ack_i;
   assign out_ack_out = st.ack_o;
   assign out_data_out = st.odata;
   assign in_active_out = st.act_i;
   assign out_active_out = st.act_o;
   assign mon_irq_out = st.irq;
   assign mon_dir_out = st.irq_dir;
   assign mon_ch_out = st.irq_ch;

   // ************************************************************
   // checks
   // ************************************************************
   a_jump_taken_val: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) jmp_valid_out |->
      (jmp_taken_out == ($past(index_val_in) != 15'h0000)) &&
      (!jmp_taken_out ||
       (bidx_we_out && bidx_wdata_out == $past(index_val_in) - 15'h0001)))
      else $error("counted jump decision or decrement wrong");
   a_jump_zero_keep: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (jmp_valid_out && !jmp_taken_out) |->
      !bidx_we_out)
      else $error("index written on fall through");
   a_jump_addr_low: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) jmp_valid_out |->
      jmp_addr_out == $past(instr_y_in))
      else $error("jump address not taken from Y");
   a_svc_incr_addr: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (st.state == ST_SVC_WR) |=>
      core_req_out && (core_addr_out == $past(cw_rdata[14:0]) + 15'h0001))
      else $error("core address not advanced before transfer");
   a_out_loc_map: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (accept && instr_j_in < `IOB_NCH_LIM &&
      instr_op_in == `IOB_OP_OBUF) |->
      cw_raddr == 5'h10 + {1'b0, instr_j_in})
      else $error("output control word location wrong");
   a_init_low_keep: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (st.state == ST_INIT_WR &&
      st.k == `IOB_K_LOW) |-> cw_we &&
      cw_wdata == {cw_rdata[29:15], st.opnd[14:0]})
      else $error("low half setup disturbed upper half");
   a_init_done_fast: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (accept && is_init &&
      instr_j_in < `IOB_NCH_LIM) |-> ##[1:2] instr_done_out)
      else $error("setup did not finish in two cycles");
   a_term_no_irq: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (accept && instr_op_in == `IOB_OP_TERM_IN &&
      instr_j_in < `IOB_NCH_LIM) |=>
      !in_active_out[$past(instr_j_in)] && !mon_irq_out)
      else $error("terminate left channel active or interrupted");
   a_silent_finish: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (st.state == ST_SVC_WR && !st.dir &&
      !st.mon_i[st.ch]) |=> !mon_irq_out)
      else $error("unmonitored buffer raised interrupt");
   a_irq_inactive: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (mon_irq_out && !mon_dir_out) |->
      !in_active_out[mon_ch_out])
      else $error("interrupt while input buffer still active");
   a_ack_in_drop: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      ((~in_ack_out & $past(in_ack_out) & $past(st.rq_i_s2)) == 12'h000))
      else $error("input ack dropped while request high");
   a_out_ack_data: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in) (st.state == ST_SVC_OUT) |=>
      out_ack_out[$past(st.ch)] &&
      out_data_out[$past(st.ch)] == $past(core_rdata_in))
      else $error("output ack without its data word");
endmodule

// >>> iob_defines.svh
// constants for the buffered channel controller
`ifndef IOB_DEFINES_SVH
`define IOB_DEFINES_SVH
`define IOB_WORD_W 30
`define IOB_HALF_W 15
`define IOB_NCH 12
`define IOB_NCH_LIM 4'hC
`define IOB_CW_DEPTH 32
`define IOB_CW_AW 5
// control word locations in core (octal 00100 and 00120)
`define IOB_LOC_BASE 15'h0040
`define IOB_LOC_IN 15'h0040
`define IOB_LOC_OUT 15'h0050
// function codes (octal 72..76, 66, 67)
`define IOB_OP_BJUMP 6'h3A
`define IOB_OP_IBUF 6'h3B
`define IOB_OP_OBUF 6'h3C
`define IOB_OP_IBUF_MON 6'h3D
`define IOB_OP_OBUF_MON 6'h3E
`define IOB_OP_TERM_IN 6'h36
`define IOB_OP_TERM_OUT 6'h37
// operand interpretation values
`define IOB_K_ADDR 2'h0
`define IOB_K_LOW 2'h1
`define IOB_K_BAD 2'h2
`define IOB_K_FULL 2'h3
`endif

// >>> iob_pkg.sv
// types for the buffered channel controller
package iob_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_INIT_WR,
      ST_SVC_WR,
      ST_SVC_WAIT,
      ST_SVC_OUT
   } iob_state_t;

   typedef struct packed {
      iob_state_t state;
      logic [3:0] ch;
      logic dir;
      logic [5:0] op;
      logic [1:0] k;
      logic [14:0] y;
      logic [29:0] opnd;
      logic [11:0] act_i;
      logic [11:0] mon_i;
      logic [11:0] act_o;
      logic [11:0] mon_o;
      logic [11:0] ack_i;
      logic [11:0] ack_o;
      logic [11:0][29:0] odata;
      logic [11:0] rq_i_s1;
      logic [11:0] rq_i_s2;
      logic [11:0] rq_o_s1;
      logic [11:0] rq_o_s2;
      logic [11:0][29:0] id_s1;
      logic [11:0][29:0] id_s2;
      logic jmp_valid;
      logic jmp_taken;
      logic [14:0] jmp_addr;
      logic b_we;
      logic [14:0] b_wdata;
      logic done;
      logic irq;
      logic irq_dir;
      logic [3:0] irq_ch;
      logic core_req;
      logic core_we;
      logic [14:0] core_addr;
      logic [29:0] core_wdata;
   } iob_regs_t;
endpackage

// >>> iob_cw_mem.sv
// control word store, one word per channel and direction
`timescale 1ns/100ps
`include "iob_defines.svh"
module iob_cw_mem
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic we_in,
   input wire logic [`IOB_CW_AW-1:0] waddr_in,
   input wire logic [`IOB_WORD_W-1:0] wdata_in,
   input wire logic [`IOB_CW_AW-1:0] raddr_in,
   output logic [`IOB_WORD_W-1:0] rdata_out
);
   logic [`IOB_WORD_W-1:0] mem [`IOB_CW_DEPTH];

   // contents are software's business after power up, so no reset
   always_ff @(posedge ref_clk_in)
   begin
      if (we_in)
         mem[waddr_in] <= wdata_in;
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         rdata_out <= 30'h0;
      else
         rdata_out <= mem[raddr_in];
   end
endmodule

// >>> iob_periph.sv
// peripheral model for the normal input and output channels
`timescale 1ns/100ps
module iob_periph
(
   input wire logic ref_clk_in,
   input wire logic [11:0] in_ack_in,
   output logic [11:0] in_req_out,
   output logic [11:0][29:0] in_data_out,
   input wire logic [11:0] out_ack_in,
   input wire logic [11:0][29:0] out_data_in,
   output logic [11:0] out_req_out
);
   int tmo = 0;

   initial
   begin
      in_req_out = '0;
      in_data_out = '0;
      out_req_out = '0;
   end

   // ***********************************************************
   // handshake helpers
   // ***********************************************************
   // acks are judged at the rising edge, before that edge's updates land
   task automatic wait_ack(input logic [3:0] ch, input logic inp,
                           input logic lvl);
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk_in);
         n++;
      end
      while ((inp ? in_ack_in[ch] : out_ack_in[ch]) !== lvl && n < 40);
      if (n >= 40)
         tmo++;
   endtask

   // gap sets the pace of the peripheral: gap plus one edges pass before its request
   task automatic send_word(input logic [3:0] ch, input logic [29:0] d,
                            input int gap);
      repeat (gap + 1) @(posedge ref_clk_in);
      #1;
      in_data_out[ch] = d;
      in_req_out[ch] = 1'b1;
      wait_ack(ch, 1'b1, 1'b1);
      #1;
      in_req_out[ch] = 1'b0;
      // released lines show no stale word
      in_data_out[ch] = ~d;
      wait_ack(ch, 1'b1, 1'b0);
      #1;
   endtask

   task automatic recv_word(input logic [3:0] ch, output logic [29:0] d,
                            input int gap);
      repeat (gap + 1) @(posedge ref_clk_in);
      #1;
      out_req_out[ch] = 1'b1;
      wait_ack(ch, 1'b0, 1'b1);
      d = out_data_in[ch];
      #1;
      out_req_out[ch] = 1'b0;
      wait_ack(ch, 1'b0, 1'b0);
      #1;
   endtask
endmodule

// >>> testbench.sv
// self-checking testbench for the buffered channel controller
`timescale 1ns/100ps
`include "iob_defines.svh"
`define CHK(a, b) begin samples_checked++; \
   if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module testbench;
   logic clk, rst, iv, rdy, done, jv, jt, bwe, creq, cwe, irq, idir;
   logic [5:0] iop;
   logic [3:0] ij, ich, irq_ch;
   logic [1:0] ik;
   logic [14:0] iy, idx, ja, bwd, caddr, wr_addr;
   logic [29:0] iopd, rdata, cwd, wr_data;
   logic [11:0] ireq, iack, oreq, oack, iact, oact;
   logic [11:0][29:0] idat, odat;
   logic irq_dir;
   logic [29:0] mem [0:32767];
   int fails = 0, samples_checked = 0, irq_cnt = 0, rd_hold = 0;

   iob_channel_ctl DUT (.ref_clk_in(clk), .sys_rst_in(rst),
      .instr_valid_in(iv), .instr_op_in(iop), .instr_j_in(ij),
      .instr_k_in(ik), .instr_y_in(iy), .instr_operand_in(iopd),
      .index_val_in(idx), .instr_ready_out(rdy), .instr_done_out(done),
      .jmp_valid_out(jv), .jmp_taken_out(jt), .jmp_addr_out(ja),
      .bidx_we_out(bwe), .bidx_wdata_out(bwd), .core_req_out(creq),
      .core_we_out(cwe), .core_addr_out(caddr), .core_wdata_out(cwd),
      .core_rdata_in(rdata), .in_req_in(ireq), .in_data_in(idat),
      .in_ack_out(iack), .out_req_in(oreq), .out_ack_out(oack),
      .out_data_out(odat), .in_active_out(iact), .out_active_out(oact),
      .mon_irq_out(irq), .mon_dir_out(idir), .mon_ch_out(ich));

   iob_periph p (.ref_clk_in(clk), .in_ack_in(iack), .in_req_out(ireq),
      .in_data_out(idat), .out_ack_in(oack), .out_data_in(odat),
      .out_req_out(oreq));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ***********************************************************
   // core storage and interrupt watch
   // ***********************************************************
   // read data holds for three edges, then turns to its inverse
   always @(posedge clk)
   begin
      if (rd_hold > 0)
      begin
         rd_hold--;
         if (rd_hold == 0)
            rdata <= #1 ~rdata;
      end
      if (creq === 1'b1 && cwe === 1'b1)
      begin
         mem[caddr] = cwd;
         wr_addr = caddr;
         wr_data = cwd;
      end
      else if (creq === 1'b1)
      begin
         rdata <= #1 mem[caddr];
         rd_hold = 3;
      end
      if (irq === 1'b1)
      begin
         irq_cnt++;
         irq_dir = idir;
         irq_ch = ich;
      end
   end

   // ***********************************************************
   // instruction issue and verdict
   // ***********************************************************
   // lat is cycles from the accepting edge to the answer pulse
   task automatic issue(input logic [5:0] op, input logic [3:0] j,
      input logic [1:0] k, input logic [14:0] y, input logic [29:0] opd,
      input logic [14:0] ix, output int lat);
      int n;
      // an edge passes first, so valid is never driven twice in one step
      @(posedge clk);
      #1;
      iop = op;
      ij = j;
      ik = k;
      iy = y;
      iopd = opd;
      idx = ix;
      iv = 1'b1;
      n = 0;
      while (rdy !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 50)
         fails++;
      @(posedge clk);
      #1;
      iv = 1'b0;
      lat = 1;
      while (done !== 1'b1 && jv !== 1'b1 && lat < 10)
      begin
         @(posedge clk);
         #1;
         lat++;
      end
      if (lat >= 10)
         fails++;
   endtask

   task automatic stop_test;
      if (fails == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic t_jump;
      int lat;
      issue(`IOB_OP_BJUMP, 4'h2, 2'h0, 15'h1234, 30'h0, 15'h0005, lat);
      `CHK(lat, 1)
      `CHK({jv, jt}, 2'b11)
      `CHK(ja, 15'h1234)
      `CHK({bwe, bwd}, {1'b1, 15'h0004})
      issue(`IOB_OP_BJUMP, 4'h3, 2'h0, 15'h0777, 30'h0, 15'h0000, lat);
      `CHK({jv, jt, bwe}, 3'b100)
   endtask

   task automatic t_in_mon;
      int lat, i;
      issue(`IOB_OP_IBUF_MON, 4'h3, `IOB_K_FULL, 15'h0050,
            {15'h0103, 15'h0100}, 15'h0, lat);
      `CHK(lat, 2)
      `CHK(iact[3], 1'b1)
      for (i = 1; i <= 3; i++)
      begin
         p.send_word(4'h3, 30'h15550000 + 30'(i), i);
         `CHK({wr_addr, wr_data}, {15'h0100 + 15'(i), 30'h15550000 + 30'(i)})
      end
      `CHK(iact[3], 1'b0)
      `CHK(irq_cnt, 1)
      `CHK({irq_dir, irq_ch}, 5'h03)
   endtask

   task automatic t_out_relow;
      int lat, i, n0;
      logic [29:0] d;
      n0 = irq_cnt;
      for (i = 0; i <= 5; i++)
         mem[15'h0200 + 15'(i)] = 30'h0ABC0000 + 30'(i);
      issue(`IOB_OP_OBUF, 4'h5, `IOB_K_FULL, 15'h0060,
            {15'h0205, 15'h0200}, 15'h0, lat);
      // a fresh start on the same channel replaces the first one
      issue(`IOB_OP_OBUF, 4'h5, `IOB_K_LOW, 15'h0061,
            {15'h7FFF, 15'h0202}, 15'h0, lat);
      `CHK(lat, 2)
      for (i = 3; i <= 5; i++)
      begin
         p.recv_word(4'h5, d, 6 - i);
         `CHK(d, 30'h0ABC0000 + 30'(i))
      end
      `CHK(oact[5], 1'b0)
      `CHK(irq_cnt, n0)
   endtask

   task automatic t_in_term;
      int lat, n0;
      n0 = irq_cnt;
      issue(`IOB_OP_IBUF, 4'h7, `IOB_K_FULL, 15'h0070,
            {15'h0310, 15'h0300}, 15'h0, lat);
      issue(`IOB_OP_IBUF, 4'h7, `IOB_K_ADDR, 15'h0305, 30'h3FFFFFFF,
            15'h0, lat);
      p.send_word(4'h7, 30'h12345678, 1);
      `CHK(wr_addr, 15'h0306)
      issue(`IOB_OP_TERM_IN, 4'h7, 2'h2, 15'h7FFF, 30'h3FFFFFFF,
            15'h7FFF, lat);
      `CHK(lat, 1)
      `CHK(iact[7], 1'b0)
      repeat (4) @(posedge clk);
      #1;
      `CHK(irq_cnt, n0)
   endtask

   task automatic t_out_mon;
      int lat, n0;
      logic [29:0] d;
      n0 = irq_cnt;
      mem[15'h0401] = 30'h02468ACE;
      issue(`IOB_OP_OBUF_MON, 4'h2, `IOB_K_FULL, 15'h0080,
            {15'h0401, 15'h0400}, 15'h0, lat);
      p.recv_word(4'h2, d, 1);
      `CHK(d, 30'h02468ACE)
      `CHK(odat[2], 30'h0)
      `CHK(oact[2], 1'b0)
      `CHK(irq_cnt, n0 + 1)
      `CHK({irq_dir, irq_ch}, 5'h12)
   endtask

   // ***********************************************************
   // main sequence and watchdog
   // ***********************************************************
   initial
   begin
      {iv, iop, ij, ik, iy, iopd, idx, rdata} = '0;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      @(posedge clk);
      #1;
      t_jump;
      t_in_mon;
      t_out_relow;
      t_in_term;
      t_out_mon;
      `CHK(p.tmo, 0)
      stop_test;
   end

   // the scenarios need about 150 cycles; this allows 20000
   initial
   begin
      #100000;
      fails++;
      stop_test;
   end
endmodule
